/* rtl/isar_slave.sv */
// Two-wire serial port front end: slave addressing, reception, transmit hold.
// Assumes open-drain pins resolved outside; control bits are plain ports.
//
// Function
// - Four-bit mode selects 7-bit slave, 10-bit slave, master or firmware mode.
// - Master clock period is four times address value plus one, in clocks.
// - Port enable hands both pins to the serial bus logic.
// - Level select picks SMBus levels when 1, standard levels when 0.
// - Bytes shift in separately, then move to buffer and raise interrupt.
// - Byte completing while buffer unread sets overflow and is dropped.
// - 10-bit first byte is 11110, A9, A8, write bit; loaded first.
// - Matched address or later data byte is acknowledged and buffered.
// - No acknowledge when buffer full or overflow already set.
// - Buffer full at completion: keep buffer, no ack, set interrupt and overflow.
// - Buffer read clears full flag; overflow cleared only by software.
// - After enable wait for START, sample eight bits on clock rise.
// - Shift bits 7:1 compared with address at eighth clock fall.
// - Clean match loads buffer at 8th fall, interrupt at 9th fall.
// - Each 10-bit address byte, except a repeated-START read, sets update flag, holds clock until address write.
// - Repeated START with read bit in 10-bit mode matches first byte only, no update.
// - Matched write address clears direction bit and is buffered.
// - Interrupt raised every matched byte except a sent byte the master does not acknowledge; software clears it and reads status.
// - Full clear but overflow set: buffer updated, interrupt, no ack.
// - Status shows START, STOP, data/address, pending update, direction.
// - Matched read: ack, hold clock until data loaded and release set.
`timescale 1ns/1ps
`default_nettype none
module isar_slave (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_o,
    output logic o_scl_oe,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Control bits
    input wire logic [3:0] i_mode,
    input wire logic i_port_enable,
    input wire logic i_level_select,
    input wire logic [7:0] i_slave_address,
    input wire logic i_address_write,
    input wire logic i_clock_release,
    // Software strobes
    input wire logic i_buffer_read,
    input wire logic i_overflow_clear,
    input wire logic i_irq_clear,
    // Transmit data
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    // Status
    output logic [7:0] o_rx_tx_buffer,
    output isar_pkg::isar_status_t o_port_status,
    output logic o_receive_overflow_flag,
    output logic o_port_interrupt_flag,
    output logic o_pins_serial,
    output logic o_smbus_levels
);
    isar_pkg::isar_pins_t pins_s;
    isar_pkg::isar_pins_t pins_d_r;
    isar_pkg::isar_state_t state_r;
    isar_pkg::isar_phase_t phase_r;
    logic [7:0] shift_reg_r;
    logic [7:0] tx_shift_r;
    logic [3:0] bit_cnt_r;
    logic ack_r;
    logic tx_mode_r;
    logic addressed10_r;
    logic host_nack_r;
    logic clock_release_bit_r;
    logic master_scl_r;
    logic [9:0] div_cnt_r;
    logic [9:0] half_period;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic slave_on;
    logic master_on;
    logic ten_bit;
    logic match_hi;
    logic match_lo;
    logic matched;
    logic byte_done;
    logic accept;
    logic ack_fall;
    logic txack_fall;
    logic irq_evt;
    logic ua_set;
    logic load_tx;
    logic [7:0] fifo_data;
    logic fifo_valid;

    // Pin synchronisers
    isar_sync #(
        .W(2),
        .RESET_VALUE(isar_pkg::PINS_IDLE)
    ) u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_async({i_scl, i_sda}),
        .o_sync(pins_s)
    );

    // Transmit data buffer
    isar_fifo #(
        .W(isar_pkg::TX_FIFO_WIDTH),
        .D(isar_pkg::TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_in_data(i_tx_data),
        .i_in_valid(i_tx_valid),
        .o_in_ready(o_tx_ready),
        .o_out_data(fifo_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(load_tx)
    );

    // Mode decode
    assign slave_on = i_port_enable & ((i_mode == isar_pkg::MODE_SLAVE7) |
        (i_mode == isar_pkg::MODE_SLAVE10));
    assign master_on = i_port_enable & (i_mode == isar_pkg::MODE_MASTER);
    assign ten_bit = (i_mode == isar_pkg::MODE_SLAVE10);

    // Bus edge and condition detection
    assign scl_rise = pins_s.scl & ~pins_d_r.scl;
    assign scl_fall = ~pins_s.scl & pins_d_r.scl;
    assign start_det = slave_on & pins_s.scl & pins_d_r.scl & pins_d_r.sda & ~pins_s.sda;
    assign stop_det = slave_on & pins_s.scl & pins_d_r.scl & ~pins_d_r.sda & pins_s.sda;

    // Address comparison
    assign match_hi = (shift_reg_r[7:1] == i_slave_address[7:1]) &
        (~ten_bit | (shift_reg_r[7:3] == isar_pkg::TEN_BIT_MARK));
    assign match_lo = (shift_reg_r == i_slave_address);
    assign matched = (phase_r == isar_pkg::PH_ADDR_HI) ? match_hi :
        (phase_r == isar_pkg::PH_ADDR_LO) ? match_lo : 1'b1;

    // Byte events
    assign byte_done = (state_r == isar_pkg::ST_RECV) & scl_fall &
        (bit_cnt_r == isar_pkg::BITS_PER_BYTE) & ~start_det & ~stop_det;
    assign accept = byte_done & matched;
    assign ack_fall = (state_r == isar_pkg::ST_ACK) & scl_fall;
    assign txack_fall = (state_r == isar_pkg::ST_TX_ACK) & scl_fall;
    assign irq_evt = ack_fall | (txack_fall & ~host_nack_r);
    assign ua_set = accept & (((phase_r == isar_pkg::PH_ADDR_HI) & ten_bit &
        ~(addressed10_r & shift_reg_r[0])) | (phase_r == isar_pkg::PH_ADDR_LO));
    assign load_tx = (state_r == isar_pkg::ST_HOLD) & tx_mode_r &
        clock_release_bit_r & fifo_valid & ~start_det & ~stop_det;

    // Pin history for edge detection
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pins_d_r <= isar_pkg::PINS_IDLE;
        end else begin
            pins_d_r <= pins_s;
        end
    end

    // Slave sequencer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= isar_pkg::ST_IDLE;
            phase_r <= isar_pkg::PH_ADDR_HI;
            shift_reg_r <= isar_pkg::BUFFER_RESET;
            tx_shift_r <= isar_pkg::BUFFER_RESET;
            bit_cnt_r <= 4'h0;
            ack_r <= 1'b0;
            tx_mode_r <= 1'b0;
            addressed10_r <= 1'b0;
            host_nack_r <= 1'b0;
        end else if (!slave_on) begin
            state_r <= isar_pkg::ST_IDLE;
            phase_r <= isar_pkg::PH_ADDR_HI;
            tx_mode_r <= 1'b0;
            addressed10_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= isar_pkg::ST_IDLE;
            phase_r <= isar_pkg::PH_ADDR_HI;
            tx_mode_r <= 1'b0;
            addressed10_r <= 1'b0;
        end else if (start_det) begin
            state_r <= isar_pkg::ST_RECV;
            phase_r <= isar_pkg::PH_ADDR_HI;
            bit_cnt_r <= 4'h0;
            tx_mode_r <= 1'b0;
        end else begin
            case (state_r)
                isar_pkg::ST_IDLE: begin
                    bit_cnt_r <= 4'h0;
                end
                isar_pkg::ST_RECV: begin
                    if (scl_rise && bit_cnt_r != isar_pkg::BITS_PER_BYTE) begin
                        shift_reg_r <= {shift_reg_r[6:0], pins_s.sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    if (byte_done) begin
                        if (!matched) begin
                            state_r <= isar_pkg::ST_IDLE;
                            addressed10_r <= 1'b0;
                        end else begin
                            state_r <= isar_pkg::ST_ACK;
                            ack_r <= ~o_port_status.buffer_full_flag &
                                ~o_receive_overflow_flag;
                            case (phase_r)
                                isar_pkg::PH_ADDR_HI: begin
                                    tx_mode_r <= shift_reg_r[0] & ~ua_set;
                                    phase_r <= ua_set ? isar_pkg::PH_ADDR_LO :
                                        isar_pkg::PH_DATA;
                                end
                                isar_pkg::PH_ADDR_LO: begin
                                    phase_r <= isar_pkg::PH_DATA;
                                    addressed10_r <= 1'b1;
                                end
                                default: begin
                                    phase_r <= isar_pkg::PH_DATA;
                                end
                            endcase
                        end
                    end
                end
                isar_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (o_port_status.update_address_flag || tx_mode_r) begin
                            state_r <= isar_pkg::ST_HOLD;
                        end else begin
                            state_r <= isar_pkg::ST_RECV;
                        end
                    end
                end
                isar_pkg::ST_HOLD: begin
                    if (load_tx) begin
                        tx_shift_r <= fifo_data;
                        bit_cnt_r <= 4'h0;
                        state_r <= isar_pkg::ST_TX;
                    end else if (!tx_mode_r && !o_port_status.update_address_flag) begin
                        bit_cnt_r <= 4'h0;
                        state_r <= isar_pkg::ST_RECV;
                    end
                end
                isar_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == isar_pkg::BITS_PER_BYTE - 4'h1) begin
                            state_r <= isar_pkg::ST_TX_ACK;
                        end else begin
                            tx_shift_r <= {tx_shift_r[6:0], 1'b1};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                isar_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        host_nack_r <= pins_s.sda;
                    end
                    if (scl_fall) begin
                        if (host_nack_r) begin
                            state_r <= isar_pkg::ST_IDLE;
                            tx_mode_r <= 1'b0;
                        end else begin
                            state_r <= isar_pkg::ST_HOLD;
                        end
                    end
                end
                default: begin
                    state_r <= isar_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Receive buffer and full flag
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_tx_buffer <= isar_pkg::BUFFER_RESET;
            o_port_status.buffer_full_flag <= 1'b0;
        end else if (accept && !o_port_status.buffer_full_flag) begin
            o_rx_tx_buffer <= shift_reg_r;
            o_port_status.buffer_full_flag <= 1'b1;
        end else if (i_buffer_read) begin
            o_port_status.buffer_full_flag <= 1'b0;
        end
    end

    // Overflow flag
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_receive_overflow_flag <= 1'b0;
        end else if (accept && o_port_status.buffer_full_flag) begin
            o_receive_overflow_flag <= 1'b1;
        end else if (i_overflow_clear) begin
            o_receive_overflow_flag <= 1'b0;
        end
    end

    // Interrupt flag
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_port_interrupt_flag <= 1'b0;
        end else if (irq_evt) begin
            o_port_interrupt_flag <= 1'b1;
        end else if (i_irq_clear) begin
            o_port_interrupt_flag <= 1'b0;
        end
    end

    // Update address flag
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_port_status.update_address_flag <= 1'b0;
        end else if (ua_set) begin
            o_port_status.update_address_flag <= 1'b1;
        end else if (i_address_write || !slave_on) begin
            o_port_status.update_address_flag <= 1'b0;
        end
    end

    // Remaining status bits
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_port_status.reserved7 <= 1'b0;
            o_port_status.smbus_levels <= 1'b0;
            o_port_status.data_not_addr <= 1'b0;
            o_port_status.stop_seen <= 1'b0;
            o_port_status.start_seen <= 1'b0;
            o_port_status.read_not_write <= 1'b0;
        end else begin
            o_port_status.reserved7 <= 1'b0;
            o_port_status.smbus_levels <= i_level_select;
            if (!i_port_enable) begin
                o_port_status.start_seen <= 1'b0;
                o_port_status.stop_seen <= 1'b0;
            end else if (start_det) begin
                o_port_status.start_seen <= 1'b1;
                o_port_status.stop_seen <= 1'b0;
            end else if (stop_det) begin
                o_port_status.stop_seen <= 1'b1;
                o_port_status.start_seen <= 1'b0;
            end
            if (accept) begin
                o_port_status.data_not_addr <= (phase_r == isar_pkg::PH_DATA);
            end
            if (accept && phase_r == isar_pkg::PH_ADDR_HI) begin
                o_port_status.read_not_write <= shift_reg_r[0];
            end
        end
    end

    // Clock release bit
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            clock_release_bit_r <= 1'b0;
        end else if (i_clock_release) begin
            clock_release_bit_r <= 1'b1;
        end else if (ack_fall || txack_fall || load_tx) begin
            clock_release_bit_r <= 1'b0;
        end
    end

    // Master bus clock divider
    assign half_period = {1'b0, i_slave_address, 1'b0} + isar_pkg::MASTER_HALF_STEP;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_cnt_r <= 10'h000;
            master_scl_r <= 1'b1;
        end else if (!master_on) begin
            div_cnt_r <= 10'h000;
            master_scl_r <= 1'b1;
        end else if (div_cnt_r >= half_period - 10'h001) begin
            div_cnt_r <= 10'h000;
            master_scl_r <= ~master_scl_r;
        end else begin
            div_cnt_r <= div_cnt_r + 10'h001;
        end
    end

    // Pin drivers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_scl_o <= 1'b1;
            o_scl_oe <= 1'b0;
            o_sda_o <= 1'b1;
            o_sda_oe <= 1'b0;
            o_pins_serial <= 1'b0;
            o_smbus_levels <= 1'b0;
        end else begin
            o_pins_serial <= i_port_enable;
            o_smbus_levels <= i_level_select;
            o_scl_o <= master_on & master_scl_r;
            o_scl_oe <= (slave_on & (state_r == isar_pkg::ST_HOLD)) |
                (master_on & ~master_scl_r);
            o_sda_o <= (state_r == isar_pkg::ST_TX) ? tx_shift_r[7] : 1'b0;
            o_sda_oe <= slave_on & (((state_r == isar_pkg::ST_ACK) & ack_r) |
                ((state_r == isar_pkg::ST_TX) & ~tx_shift_r[7]));
        end
    end
endmodule // isar_slave
`default_nettype wire

/* rtl/isar_pkg.sv */
// Constants, carriers and state types of the slave front end.
// Assumes every design file refers to these items by package scope.
package isar_pkg;

    // Bus mode field values
    localparam logic [3:0] MODE_SLAVE7 = 4'h0;
    localparam logic [3:0] MODE_SLAVE10 = 4'h1;
    localparam logic [3:0] MODE_MASTER = 4'h2;
    localparam logic [3:0] MODE_FIRMWARE = 4'h3;

    // Leading bits of a 10-bit first address byte
    localparam logic [4:0] TEN_BIT_MARK = 5'h1e;

    // Bits in one byte on the bus
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Master clock half-period step
    localparam logic [9:0] MASTER_HALF_STEP = 10'h002;

    // Transmit FIFO shape
    localparam int TX_FIFO_WIDTH = 8;
    localparam int TX_FIFO_DEPTH = 8;

    // Reset values
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] PINS_IDLE = 2'h3;

    // Status register, bit 7 first
    typedef struct packed {
        logic reserved7;
        logic smbus_levels;
        logic data_not_addr;
        logic stop_seen;
        logic start_seen;
        logic read_not_write;
        logic update_address_flag;
        logic buffer_full_flag;
    } isar_status_t;

    // Two-wire bus levels
    typedef struct packed {
        logic scl;
        logic sda;
    } isar_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_HOLD,
        ST_TX,
        ST_TX_ACK
    } isar_state_t;

    typedef enum logic [1:0] {
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_DATA
    } isar_phase_t;

endpackage

/* rtl/isar_sync.sv */
// Two-flop synchroniser for levels arriving from the bus pins.
// Assumes the inputs are asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module isar_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RESET_VALUE = '1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_r <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // isar_sync
`default_nettype wire

/* rtl/isar_fifo.sv */
// Parameterised FIFO with valid/ready on both sides.
// Assumes both sides run on i_clk; output data is valid with o_out_valid.
`timescale 1ns/1ps
`default_nettype none
module isar_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Fill side
    input wire logic [W-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    // Drain side
    output logic [W-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic push;
    logic pop;

    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    assign count_nxt = count_r + CW'(push) - CW'(pop);
    assign o_out_data = mem[rd_ptr_r];

    // Storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers and flags
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            o_in_ready <= 1'b1;
            o_out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_nxt;
            o_in_ready <= (count_nxt != CW'(D));
            o_out_valid <= (count_nxt != '0);
        end
    end
endmodule // isar_fifo
`default_nettype wire

/* tb/isar_properties.sv */
// Port properties of the slave front end.
// Assumes a bind to isar_slave.
`timescale 1ns/1ps
`default_nettype none
module isar_properties (
    // Clock, reset, inputs
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [3:0] i_mode,
    input wire logic i_port_enable,
    input wire logic i_level_select,
    input wire logic i_address_write,
    // Outputs
    input wire logic o_scl_oe,
    input wire logic o_sda_oe,
    input wire logic [7:0] o_rx_tx_buffer,
    input wire isar_pkg::isar_status_t o_port_status,
    input wire logic o_receive_overflow_flag,
    input wire logic o_smbus_levels,
    input wire logic o_port_interrupt_flag
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_load;
        $rose(o_port_status.buffer_full_flag);
    endsequence
    sequence s_unhold;
        ##[1:4] !o_port_status.update_address_flag ##[0:4] !o_scl_oe;
    endsequence
    AST_LEVELS: assert property ($past(i_resetn) |-> o_smbus_levels == $past(i_level_select))
        else $error("level lag");
    AST_ACK: assert property (s_load ##0 !o_receive_overflow_flag |=> o_sda_oe)
        else $error("no ack");
    AST_NOACK: assert property (s_load ##0 $past(o_receive_overflow_flag) |-> !o_sda_oe [*4])
        else $error("ack with overflow");
    AST_KEEP: assert property ($rose(o_receive_overflow_flag) |-> $stable(o_rx_tx_buffer)
        ##0 !o_sda_oe [*4]) else $error("byte not dropped");
    AST_IRQ: assert property ($fell(o_sda_oe) && !o_port_status.read_not_write
        |-> o_port_interrupt_flag) else $error("no interrupt");
    AST_HOLD: assert property (o_port_status.update_address_flag && o_scl_oe |=> o_scl_oe)
        else $error("clock released early");
    AST_REL: assert property (i_address_write && o_port_status.update_address_flag
        |-> s_unhold) else $error("clock not released");
    AST_START: assert property (i_port_enable && i_mode[3:1] == 3'h0 && i_scl
        && $past(i_scl) && $fell(i_sda) |-> ##[1:8] o_port_status.start_seen)
        else $error("start not reported");
endmodule // isar_properties
`default_nettype wire

/* tb/isar_master_model.sv */
// Bus master model with open-drain releases.
// Assumes pull-ups on both wires.
`timescale 1ns/1ps
`default_nettype none
module isar_master_model (
    // Clock and resolved wires
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    // Releases, 1 = released
    output logic o_scl = 1'b1,
    output logic o_sda = 1'b1
);
    localparam int H = 12;
    task automatic wt(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    // Clock high; waits out stretching
    task automatic rise();
        o_scl = 1'b1;
        for (int k = 0; k < 3000 && i_scl !== 1'b1; k++) wt(1);
        wt(H);
    endtask
    task automatic start();
        o_sda = 1'b1;
        wt(H);
        rise();
        o_sda = 1'b0;
        wt(H);
        o_scl = 1'b0;
        wt(H);
    endtask
    task automatic stop();
        o_sda = 1'b0;
        wt(H);
        rise();
        o_sda = 1'b1;
        wt(H);
    endtask
    // Eight bits MSB first, data set while clock low
    task automatic xfer(input logic [7:0] b, input logic n9, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda = b[i];
            wt(H);
            rise();
            q[i] = i_sda;
            o_scl = 1'b0;
        end
        o_sda = n9;
        wt(H);
        rise();
        ack = !i_sda;
        o_scl = 1'b0;
        wt(2);
    endtask
endmodule // isar_master_model
`default_nettype wire

/* tb/testbench.sv */
// Bench: random and corner bus traffic via a master model.
// Assumes pull-ups on both wires.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_port_enable = 1'b0, i_level_select = 1'b0;
    logic i_address_write = 1'b0, i_clock_release = 1'b0, i_buffer_read = 1'b0;
    logic i_overflow_clear = 1'b0, i_irq_clear = 1'b0, i_tx_valid = 1'b0, ack, m_scl, m_sda;
    logic [3:0] i_mode = 4'h0;
    logic [7:0] i_slave_address = 8'h00, i_tx_data = 8'h00, q, a, d, o_rx_tx_buffer;
    logic [7:0] fq [8];
    logic o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_tx_ready, o_receive_overflow_flag;
    logic o_port_interrupt_flag, o_pins_serial, o_smbus_levels;
    isar_pkg::isar_status_t o_port_status;
    wire logic i_scl = m_scl & ~o_scl_oe;
    wire logic i_sda = m_sda & ~o_sda_oe;
    int n_errors = 0, num_checks = 0, cyc = 0, seed = 55, n;
    always #5 i_clk = ~i_clk;
    isar_slave u_isar_slave (.*);
    isar_master_model u_isar_master_model (.i_clk(i_clk), .i_scl(i_scl), .i_sda(i_sda),
        .o_scl(m_scl), .o_sda(m_sda));
    task automatic wt(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        wt(1);
        s = 1'b0;
    endtask
    task automatic clr();
        pulse(i_buffer_read);
        pulse(i_irq_clear);
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] est(input logic da, input logic rw, input logic ua,
        input logic bf);
        return {2'h0, da, 2'h1, rw, ua, bf};
    endfunction
    // Master writes a byte; results compared
    task automatic by(input logic [7:0] b, input logic [1:0] e, input logic [7:0] eb,
        input logic [7:0] es);
        u_isar_master_model.xfer(b, 1'b1, q, ack);
        wt(8);
        cmp({6'h0, ack, o_port_interrupt_flag}, {6'h0, e});
        cmp(o_rx_tx_buffer, eb);
        cmp(o_port_status, es);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        wt(8);
        i_resetn = 1'b1;
        wt(2);
        cmp(o_port_status, isar_pkg::STATUS_RESET);
        cmp(o_rx_tx_buffer, isar_pkg::BUFFER_RESET);
        for (int m = 3; m >= 0; m--) begin
            i_mode = 4'(m);
            i_level_select = m[0];
            i_port_enable = 1'b1;
            wt(8);
            cmp({7'h0, o_smbus_levels}, {7'h0, i_level_select});
        end
        cmp({7'h0, o_pins_serial}, 8'h01);
        a = {7'($random(seed)), 1'b0};
        i_slave_address = a;
        u_isar_master_model.start();
        by(a, 2'h3, a, est(1'b0, 1'b0, 1'b0, 1'b1));
        d = 8'($random(seed));
        by(d, 2'h1, a, est(1'b1, 1'b0, 1'b0, 1'b1));
        pulse(i_buffer_read);
        cmp({6'h0, o_receive_overflow_flag, o_port_status[0]}, 8'h02);
        d = 8'($random(seed));
        by(d, 2'h1, d, est(1'b1, 1'b0, 1'b0, 1'b1));
        clr();
        pulse(i_overflow_clear);
        repeat (3) begin
            d = 8'($random(seed));
            by(d, 2'h3, d, est(1'b1, 1'b0, 1'b0, 1'b1));
            clr();
        end
        u_isar_master_model.start();
        by(~a, 2'h0, d, est(1'b1, 1'b0, 1'b0, 1'b0));
        u_isar_master_model.stop();
        wt(8);
        cmp({7'h0, o_port_status.stop_seen}, 8'h01);
        i_mode = isar_pkg::MODE_SLAVE10;
        a = {isar_pkg::TEN_BIT_MARK, 2'($random(seed)), 1'b0};
        d = 8'($random(seed));
        i_slave_address = a;
        u_isar_master_model.start();
        by(a, 2'h3, a, est(1'b0, 1'b0, 1'b1, 1'b1));
        cmp({7'h0, o_scl_oe}, 8'h01);
        i_slave_address = d;
        pulse(i_address_write);
        clr();
        by(d, 2'h3, d, est(1'b0, 1'b0, 1'b1, 1'b1));
        i_slave_address = a;
        pulse(i_address_write);
        clr();
        u_isar_master_model.start();
        by(a | 8'h01, 2'h3, a | 8'h01, est(1'b0, 1'b1, 1'b0, 1'b1));
        pulse(i_buffer_read);
        n = 0;
        while (n < 12 && o_tx_ready === 1'b1) begin
            fq[n[2:0]] = 8'($random(seed));
            i_tx_data = fq[n[2:0]];
            i_tx_valid = 1'b1;
            wt(1);
            n++;
        end
        i_tx_valid = 1'b0;
        cmp(8'(n), 8'h08);
        for (int i = 0; i < 8; i++) begin
            pulse(i_clock_release);
            u_isar_master_model.xfer(8'hff, i == 7, q, ack);
            cmp(q, fq[i]);
            wt(8);
        end
        cmp({7'h0, o_tx_ready}, 8'h01);
        u_isar_master_model.stop();
        print_verdict();
    end
endmodule // testbench
bind isar_slave isar_properties u_isar_properties (.*);
`default_nettype wire
